// ### tpw_timer.sv
// 8-bit timer/counter with one compare channel and waveform output
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
// Behaviour
// - Fast PWM mode 1 toggles on match
// - Mode 1 counts up then down
// - Phase PWM: clear up, set down
// - Phase PWM: COM 2 normal, 3 inverted
// - Eight-bit, MAX held one tick
// - Phase PWM overflow flag at BOTTOM
// - Pin driven only when direction output
// - Phase PWM: compare BOTTOM/MAX give constant levels
// - Level at MAX equals up-match result, except compare MAX
// - Missed up-match still changes output
// - Phase period 510 ticks times prescale
// - Counter advances only on timer tick
// - Force strobe matches in non-PWM only
// - Force strobe sets no flag, no clear
// - Force bit reads as zero
// - Mode field selects sequence and TOP
// - Compare buffer and overflow timing per mode
// - Clock select picks tick divider
// - Non-PWM COM: off, toggle, clear, set
module tpw_timer (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic async_osc_tick_i,
  input wire logic async_sel_i,
  input wire tpw_pkg::tpw_bus_s bus_i,
  output logic [7:0] rdata_o,
  output logic compare_output_pin_o,
  output logic compare_output_pin_oe_o,
  output logic overflow_flag_o,
  output logic compare_match_flag_a_o
);
  import tpw_pkg::*;

  logic [7:0] ctrl_q;
  logic [7:0] counter_value_q;
  logic [7:0] compare_value_a_q;
  logic [7:0] compare_buf_q;
  logic down_q;
  logic compare_output_a_q;
  logic overflow_flag_q;
  logic compare_match_flag_a_q;
  logic port_dir_q;
  logic [9:0] prescale_q;
  logic block_match_q;
  logic [7:0] rdata_q;
  logic pin_q;
  logic pin_oe_q;
  logic timer_tick;
  logic src_tick;
  logic is_pwm;
  logic match;
  logic force_hit;
  logic [1:0] com;
  tpw_wgm_e wgm;
  logic wr_ctrl;
  logic wr_cnt;
  logic wr_cmp;
  logic wr_flags;
  logic at_top;
  logic [7:0] cnt_d;
  logic dir_d;
  logic oc_d;

  function automatic logic sel(input logic [2:0] a, input logic [2:0] b);
    sel = (a == b);
  endfunction

  assign wr_ctrl = bus_i.wr && sel(bus_i.addr, ADDR_CTRL_A);
  assign wr_cnt = bus_i.wr && sel(bus_i.addr, ADDR_COUNTER);
  assign wr_cmp = bus_i.wr && sel(bus_i.addr, ADDR_COMPARE_A);
  assign wr_flags = bus_i.wr && sel(bus_i.addr, ADDR_FLAGS);
  assign wgm = tpw_wgm_e'({ctrl_q[WGM1_BIT], ctrl_q[WGM0_BIT]});
  assign com = ctrl_q[COM_HI:COM_LO];
  assign is_pwm = ctrl_q[WGM0_BIT];
  assign src_tick = async_sel_i ? async_osc_tick_i : 1'b1;

  // Prescaler, free running on the source tick
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      prescale_q <= 10'h000;
    end else if (src_tick) begin
      prescale_q <= prescale_q + 10'h001;
    end
  end

  // Tick enable chosen by clock select
  always_comb begin
    case (ctrl_q[CS_HI:CS_LO])
      3'h0: timer_tick = 1'b0;
      3'h1: timer_tick = src_tick;
      3'h2: timer_tick = src_tick && (prescale_q[2:0] == 3'h7);
      3'h3: timer_tick = src_tick && (prescale_q[4:0] == 5'h1f);
      3'h4: timer_tick = src_tick && (prescale_q[5:0] == 6'h3f);
      3'h5: timer_tick = src_tick && (prescale_q[6:0] == 7'h7f);
      3'h6: timer_tick = src_tick && (prescale_q[7:0] == 8'hff);
      // Divide by 1024 waits for the full prescaler
      default: timer_tick = src_tick && (prescale_q == PRESCALE_TOP);
    endcase
  end

  // TOP in use for the present mode
  assign at_top = (wgm == WGM_CLEAR_ON_MATCH) ?
                  (counter_value_q == compare_value_a_q) :
                  (counter_value_q == CNT_MAX);
  assign match = timer_tick && !block_match_q &&
                 (counter_value_q == compare_value_a_q);
  assign force_hit = wr_ctrl && bus_i.wdata[FOC_BIT] &&
                     !bus_i.wdata[WGM0_BIT];

  // Counter sequence
  always_comb begin
    cnt_d = counter_value_q;
    dir_d = down_q;
    if (timer_tick) begin
      case (wgm)
        WGM_PHASE_PWM: begin
          // Holds MAX one tick, then turns; 510 ticks per period
          if (!down_q && counter_value_q == CNT_MAX) begin
            dir_d = 1'b1;
            cnt_d = counter_value_q - 8'h01;
          end else if (down_q && counter_value_q == CNT_BOTTOM) begin
            dir_d = 1'b0;
            cnt_d = counter_value_q + 8'h01;
          end else if (down_q) begin
            cnt_d = counter_value_q - 8'h01;
          end else begin
            cnt_d = counter_value_q + 8'h01;
          end
        end
        WGM_CLEAR_ON_MATCH: begin
          cnt_d = at_top ? CNT_BOTTOM : counter_value_q + 8'h01;
          dir_d = 1'b0;
        end
        default: begin
          cnt_d = counter_value_q + 8'h01;
          dir_d = 1'b0;
        end
      endcase
    end
    if (wr_cnt) begin
      cnt_d = bus_i.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      counter_value_q <= CNT_BOTTOM;
      down_q <= 1'b0;
      block_match_q <= 1'b0;
    end else begin
      counter_value_q <= cnt_d;
      down_q <= dir_d;
      // A counter write hides the match on the next tick
      if (wr_cnt) begin
        block_match_q <= 1'b1;
      end else if (timer_tick) begin
        block_match_q <= 1'b0;
      end
    end
  end

  // Control, compare and direction registers
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ctrl_q <= CTRL_RESET;
      compare_buf_q <= CNT_BOTTOM;
      compare_value_a_q <= CNT_BOTTOM;
      port_dir_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= bus_i.wdata & CTRL_READ_MASK;
      end
      if (wr_cmp) begin
        compare_buf_q <= bus_i.wdata;
      end
      if (bus_i.wr && sel(bus_i.addr, ADDR_PORT_DIR)) begin
        port_dir_q <= bus_i.wdata[0];
      end
      // Double buffered at TOP in PWM modes, else immediate
      if (!is_pwm) begin
        compare_value_a_q <= wr_cmp ? bus_i.wdata : compare_buf_q;
      end else if (timer_tick && counter_value_q == CNT_MAX) begin
        compare_value_a_q <= compare_buf_q;
      end
    end
  end

  // Waveform generator
  always_comb begin
    oc_d = compare_output_a_q;
    case (wgm)
      WGM_PHASE_PWM: begin
        if (com[1] && timer_tick) begin
          if (!down_q && counter_value_q == CNT_MAX) begin
            // At TOP the level is the up-match result, which also
            // makes good a match missed on the way up; a compare
            // of MAX keeps the down-match level instead
            if (compare_buf_q == CNT_MAX) begin
              oc_d = !com[0];
            end else begin
              oc_d = com[0];
            end
          end else if (counter_value_q == CNT_BOTTOM &&
                       compare_value_a_q == CNT_BOTTOM) begin
            // Both matches meet at BOTTOM; the up-match wins
            oc_d = com[0];
          end else if (match) begin
            oc_d = down_q ? !com[0] : com[0];
          end
        end
      end
      WGM_FAST_PWM: begin
        if (timer_tick) begin
          if (com == 2'b01 && match) begin
            oc_d = !compare_output_a_q;
          end else if (com[1] && counter_value_q == CNT_MAX) begin
            oc_d = !com[0];
          end else if (com[1] && match) begin
            oc_d = com[0];
          end
        end
      end
      default: begin
        if (match || force_hit) begin
          case (force_hit ? bus_i.wdata[COM_HI:COM_LO] : com)
            2'b01: oc_d = !compare_output_a_q;
            2'b10: oc_d = 1'b0;
            2'b11: oc_d = 1'b1;
            default: oc_d = compare_output_a_q;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      compare_output_a_q <= 1'b0;
    end else begin
      compare_output_a_q <= oc_d;
    end
  end

  // Flags: hardware set wins over software clear by writing one
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      overflow_flag_q <= 1'b0;
      compare_match_flag_a_q <= 1'b0;
    end else begin
      // Phase mode flags BOTTOM as the counter steps 1 to 0
      if (timer_tick && (is_pwm && !ctrl_q[WGM1_BIT] ?
          (down_q && counter_value_q == 8'h01) :
          (counter_value_q == CNT_MAX))) begin
        overflow_flag_q <= 1'b1;
      end else if (wr_flags && bus_i.wdata[OVF_BIT]) begin
        overflow_flag_q <= 1'b0;
      end
      if (match) begin
        compare_match_flag_a_q <= 1'b1;
      end else if (wr_flags && bus_i.wdata[CMF_BIT]) begin
        compare_match_flag_a_q <= 1'b0;
      end
    end
  end

  // Pin output and read data
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pin_q <= 1'b0;
      pin_oe_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      // Pin follows the waveform only while connected
      pin_q <= (com != 2'b00) ? oc_d : 1'b0;
      pin_oe_q <= port_dir_q;
      rdata_q <= 8'h00;
      if (bus_i.rd) begin
        case (bus_i.addr)
          ADDR_CTRL_A: rdata_q <= ctrl_q & CTRL_READ_MASK;
          ADDR_COUNTER: rdata_q <= counter_value_q;
          ADDR_COMPARE_A: rdata_q <= compare_buf_q;
          ADDR_FLAGS: rdata_q <= {6'h00, compare_match_flag_a_q,
                                  overflow_flag_q};
          ADDR_PORT_DIR: rdata_q <= {7'h00, port_dir_q};
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end

  assign rdata_o = rdata_q;
  assign compare_output_pin_o = pin_q;
  assign compare_output_pin_oe_o = pin_oe_q;
  assign overflow_flag_o = overflow_flag_q;
  assign compare_match_flag_a_o = compare_match_flag_a_q;
endmodule // tpw_timer

// ### tpw_pkg.sv
// Package for the 8-bit timer with PWM waveform unit
package tpw_pkg;
  // Register offsets (plain port, 8-bit data)
  localparam logic [2:0] ADDR_CTRL_A = 3'h0;
  localparam logic [2:0] ADDR_COUNTER = 3'h1;
  localparam logic [2:0] ADDR_COMPARE_A = 3'h2;
  localparam logic [2:0] ADDR_FLAGS = 3'h3;
  localparam logic [2:0] ADDR_PORT_DIR = 3'h4;
  // Control register field positions
  localparam int FOC_BIT = 7;
  localparam int WGM0_BIT = 6;
  localparam int COM_HI = 5;
  localparam int COM_LO = 4;
  localparam int WGM1_BIT = 3;
  localparam int CS_HI = 2;
  localparam int CS_LO = 0;
  // Flags register bit positions
  localparam int OVF_BIT = 0;
  localparam int CMF_BIT = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_READ_MASK = 8'h7f;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [9:0] PRESCALE_TOP = 10'h3ff;

  typedef enum logic [1:0] {
    WGM_NORMAL = 2'b00,
    WGM_PHASE_PWM = 2'b01,
    WGM_CLEAR_ON_MATCH = 2'b10,
    WGM_FAST_PWM = 2'b11
  } tpw_wgm_e;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tpw_bus_s;
endpackage

// ### tpw_timer_props.sv
// Port-level checker for the timer
`timescale 1ns/1ps
module tpw_timer_props (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire tpw_pkg::tpw_bus_s bus_i,
  input wire logic [7:0] rdata_o,
  input wire logic compare_output_pin_o,
  input wire logic compare_output_pin_oe_o,
  input wire logic overflow_flag_o,
  input wire logic compare_match_flag_a_o
);
  import tpw_pkg::*;
  logic [7:0] ctl_q;
  logic [7:0] cmp_q;
  logic wr0;
  assign wr0 = bus_i.wr && bus_i.addr == ADDR_CTRL_A;
  // Shadow copies of software-written registers
  always_ff @(posedge clk_i) begin
    if (!resetn_i) ctl_q <= CTRL_RESET;
    else if (wr0) ctl_q <= bus_i.wdata;
  end
  always_ff @(posedge clk_i) begin
    if (!resetn_i) cmp_q <= 8'h00;
    else if (bus_i.wr && bus_i.addr == ADDR_COMPARE_A) cmp_q <= bus_i.wdata;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence frc_s(logic [1:0] c);
    wr0 && bus_i.wdata[7:6] == 2'b10 && !bus_i.wdata[3]
      && bus_i.wdata[5:4] == c;
  endsequence
  sequence com_off_s;
    (ctl_q[5:4] == 2'b00) [*3];
  endsequence
  AST_CTRL_READ: assert property (
    bus_i.rd && bus_i.addr == ADDR_CTRL_A
      |=> rdata_o == ($past(ctl_q) & CTRL_READ_MASK))
    else $error("control readback wrong");
  AST_CMP_READ: assert property (
    bus_i.rd && bus_i.addr == ADDR_COMPARE_A |=> rdata_o == $past(cmp_q))
    else $error("compare readback wrong");
  AST_DIR_ON: assert property (
    bus_i.wr && bus_i.addr == ADDR_PORT_DIR && bus_i.wdata[0]
      |-> ##2 compare_output_pin_oe_o)
    else $error("pin not enabled");
  AST_DIR_OFF: assert property (
    bus_i.wr && bus_i.addr == ADDR_PORT_DIR && !bus_i.wdata[0]
      |-> ##2 !compare_output_pin_oe_o)
    else $error("pin not released");
  AST_COM_OFF: assert property (com_off_s |-> !compare_output_pin_o)
    else $error("pin driven while disconnected");
  AST_FRC_SET: assert property (
    frc_s(2'b11) |-> ##[1:3] compare_output_pin_o)
    else $error("forced set missing");
  AST_FRC_CLR: assert property (
    frc_s(2'b10) |-> ##[1:3] !compare_output_pin_o)
    else $error("forced clear missing");
  AST_FRC_NOFLAG: assert property (
    wr0 && bus_i.wdata[7] && ctl_q[2:0] == 3'h0 && bus_i.wdata[2:0] == 3'h0
      && !compare_match_flag_a_o |=> !compare_match_flag_a_o [*3])
    else $error("forced match set a flag");
  AST_OVF_STICKY: assert property (
    overflow_flag_o && !(bus_i.wr && bus_i.addr == ADDR_FLAGS
      && bus_i.wdata[OVF_BIT]) |=> overflow_flag_o)
    else $error("overflow flag lost");
endmodule // tpw_timer_props

// ### tpw_timer_tb.sv
// Self-checking bench for the timer
`timescale 1ns/1ps
module tpw_timer_tb;
  import tpw_pkg::*;
  logic clk_i = 0, resetn_i = 0, tick = 0, asel = 0;
  tpw_bus_s bus = '0;
  logic [7:0] rdata;
  logic pin, oe, ovf, cmf;
  int fail_count = 0, n_compared = 0, cnt;
  time t0;
  int ps[3] = '{1, 8, 32};
  logic [7:0] fv[4] = '{8'hb0, 8'ha0, 8'h90, 8'h90};
  // Mode word, compare value, half the high count over one period
  logic [7:0] lv[6][3] = '{'{8'h61, 8'h00, 8'h00}, '{8'h61, 8'hff, 8'hff},
    '{8'h71, 8'h00, 8'hff}, '{8'h71, 8'hff, 8'h00},
    '{8'h61, 8'h80, 8'h80}, '{8'h71, 8'h80, 8'h7f}};
  always #2 clk_i = ~clk_i;
  tpw_timer tpw_timer_i (.clk_i(clk_i), .resetn_i(resetn_i),
    .async_osc_tick_i(tick), .async_sel_i(asel), .bus_i(bus),
    .rdata_o(rdata), .compare_output_pin_o(pin),
    .compare_output_pin_oe_o(oe), .overflow_flag_o(ovf),
    .compare_match_flag_a_o(cmf));
  task automatic final_report;
    if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_i);
    bus <= '0;
    @(posedge clk_i);
  endtask
  task automatic rd(logic [2:0] a, logic [7:0] e, string nm);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_i);
    bus <= '0;
    #1 chk(nm, rdata, e);
    @(posedge clk_i);
  endtask
  task automatic look(string nm, ref logic v, input logic e);
    repeat (2) @(posedge clk_i);
    #1 chk(nm, v, e);
    @(posedge clk_i);
  endtask
  task automatic highs(int n);
    cnt = 0;
    repeat (n) begin
      @(negedge clk_i);
      if (pin === 1'b1) cnt++;
    end
    @(posedge clk_i);
  endtask
  task automatic wait_ovf(int n);
    repeat (n) begin
      @(posedge clk_i);
      #1;
      if (ovf === 1'b1) begin
        @(posedge clk_i);
        return;
      end
    end
    fail_count++;
    final_report();
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    resetn_i <= 1;
    @(posedge clk_i);
    rd(ADDR_CTRL_A, 8'h00, "ctrl reset");
    rd(ADDR_FLAGS, 8'h00, "flags reset");
    rd(3'h5, 8'h00, "unmapped");
    wr(ADDR_CTRL_A, 8'hb7);
    rd(ADDR_CTRL_A, 8'h37, "ctrl force bit");
    wr(ADDR_PORT_DIR, 8'h01);
    look("oe", oe, 1'b1);
    wr(ADDR_CTRL_A, 8'h30);
    wr(ADDR_FLAGS, 8'h03);
    foreach (fv[i]) begin
      wr(ADDR_CTRL_A, fv[i]);
      look("force pin", pin, fv[i][5] ? fv[i][4] : !i[0]);
    end
    look("force flag", cmf, 1'b0);
    wr(ADDR_CTRL_A, 8'h00);
    wr(ADDR_COUNTER, 8'h05);
    repeat (20) @(posedge clk_i);
    rd(ADDR_COUNTER, 8'h05, "stopped");
    asel <= 1;
    wr(ADDR_CTRL_A, 8'h01);
    repeat (3) begin
      tick <= 1;
      @(posedge clk_i);
      tick <= 0;
      repeat (3) @(posedge clk_i);
    end
    rd(ADDR_COUNTER, 8'h08, "osc ticks");
    asel <= 0;
    wr(ADDR_COMPARE_A, 8'h10);
    wr(ADDR_FLAGS, 8'h03);
    wait_ovf(300);
    chk("match flag", cmf, 1'b1);
    foreach (ps[i]) begin
      wr(ADDR_CTRL_A, 8'h60 | 8'(i + 1));
      wr(ADDR_FLAGS, 8'h03);
      wait_ovf(600 * ps[i]);
      t0 = $time;
      wr(ADDR_FLAGS, 8'h03);
      wait_ovf(600 * ps[i]);
      chk("period", 16'(($time - t0) / 4), 16'(510 * ps[i]));
    end
    foreach (lv[i]) begin
      wr(ADDR_CTRL_A, lv[i][0]);
      wr(ADDR_COMPARE_A, lv[i][1]);
      repeat (600) @(posedge clk_i);
      highs(510);
      chk("level", 16'(cnt), {7'h00, lv[i][2], 1'b0});
    end
    wr(ADDR_CTRL_A, 8'h59);
    repeat (600) @(posedge clk_i);
    highs(512);
    chk("toggle duty", 16'(cnt), 16'h0100);
    wr(ADDR_CTRL_A, 8'h19);
    wr(ADDR_COMPARE_A, 8'h09);
    rd(ADDR_COMPARE_A, 8'h09, "compare");
    repeat (600) @(posedge clk_i);
    highs(200);
    chk("match toggle", 16'(cnt), 16'h0064);
    wr(ADDR_PORT_DIR, 8'h00);
    look("oe off", oe, 1'b0);
    final_report();
  end
endmodule // tpw_timer_tb
bind tpw_timer tpw_timer_props tpw_timer_props_i (.clk_i(clk_i),
  .resetn_i(resetn_i), .bus_i(bus_i), .rdata_o(rdata_o),
  .compare_output_pin_o(compare_output_pin_o),
  .compare_output_pin_oe_o(compare_output_pin_oe_o),
  .overflow_flag_o(overflow_flag_o),
  .compare_match_flag_a_o(compare_match_flag_a_o));
